// ==== inc/timer16_oc_map.svh ====
// register offsets, mode codes and fixed values of the 16-bit timer compare block
`ifndef TIMER16_OC_MAP_SVH
`define TIMER16_OC_MAP_SVH
`define OFS_CTRL 8'h00
`define OFS_CNT_LO 8'h04
`define OFS_CNT_HI 8'h08
`define OFS_CMPA_LO 8'h0C
`define OFS_CMPA_HI 8'h10
`define OFS_CMPB_LO 8'h14
`define OFS_CMPB_HI 8'h18
`define OFS_FLAGS 8'h1C
`define OFS_IRQEN 8'h20
`define OFS_FORCE 8'h24
`define MODE_NORMAL 4'h0
`define MODE_PC8 4'h1
`define MODE_PC9 4'h2
`define MODE_PC10 4'h3
`define MODE_CLR_A 4'h4
`define MODE_FAST8 4'h5
`define MODE_FAST9 4'h6
`define MODE_FAST10 4'h7
`define MODE_PFC_CAP 4'h8
`define MODE_PFC_A 4'h9
`define MODE_PC_CAP 4'hA
`define MODE_PC_A 4'hB
`define MODE_CLR_CAP 4'hC
`define MODE_RSVD 4'hD
`define MODE_FAST_CAP 4'hE
`define MODE_FAST_A 4'hF
`define TOP_MAX 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define BOTTOM 16'h0000
`define ACT_NONE 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3
`define ACT_PWM_NONINV 2'h2
`define ACT_PWM_INV 2'h3
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7
`define PRE_DIV8 10'h007
`define PRE_DIV64 10'h03F
`define PRE_DIV256 10'h0FF
`define PRE_DIV1024 10'h3FF
`define IDX_OVF 2
`endif

// ==== inc/timer16_oc_pkg.sv ====
// types shared by the timer compare block and its bench
package timer16_oc_pkg;
  typedef struct packed {
    logic [16:0] rsvd;
    logic [1:0] port_val;
    logic [1:0] pin_direction_bit;
    logic [2:0] clock_source_sel;
    logic [1:0][1:0] output_action_sel;
    logic [3:0] waveform_mode_sel;
  } ctrl_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] timer_count;
    logic [7:0] hi_latch;
    logic [7:0] rd_hi;
    logic [1:0][15:0] cmp_buf;
    logic [1:0][15:0] compare_value;
    logic [2:0] flags;
    logic [2:0] irq_en;
    logic [1:0] compare_output_bit;
    logic block;
    logic down;
    logic ext_prev;
    logic [9:0] presc;
    logic [31:0] rdata;
    logic slverr;
  } state_t;
endpackage

// ==== hdl/timer16_oc.sv ====
// 16-bit timer counter with two output compare channels behind an apb slave
// Behaviour
// - compare full count to each value always
// - match sets flag, drives waveform output
// - enabled flag requests irq; ack/one clears
// - channel a value can serve as top
// - double buffer in pwm, not normal/clear
// - buffer copies to active at top/bottom
// - cpu targets buffer or active, no latch read
// - high byte latched, low write commits word
// - force strobe acts like match outside pwm modes, no flag
// - count write blocks next timer tick matches
// - output action change applies at next match or force
// - output bit resets zero, survives mode change
// - nonzero action overrides port value on pin
// - action zero leaves output unchanged
// - output action never touches input capture
// - counting depends only on waveform mode
// - set/clear/toggle or pwm polarity by action
// - mode zero counts up, wraps, writable
// - overflow flag at max in normal/clear, top in fast, bottom in dual
// - cpu count write beats clear or count
// - clock select zero stops the counter
// - pwm action two noninverted, three inverted
`timescale 1ns/1ps
`include "timer16_oc_map.svh"
module timer16_oc #(
  parameter int NUM_CH = 2
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire timer16_oc_pkg::apb_req_t APB_REQ,
  output timer16_oc_pkg::apb_rsp_t APB_RSP,
  input wire logic EXT_CLK_IN,
  input wire logic [15:0] CAPTURE_VALUE,
  input wire logic [2:0] IRQ_ACK,
  output logic [2:0] IRQ_REQ,
  output logic [1:0] OC_PIN_OUT,
  output logic [1:0] OC_PIN_OE
);
  import timer16_oc_pkg::*;

  // channel a doubles as top source, so the logic is built for exactly two
  if (NUM_CH != 2) begin : g_bad_ch
    $error("timer16_oc supports exactly two compare channels");
  end

  state_t q;
  state_t d;
  logic tick;
  logic pwm;
  logic dual;
  logic clr_mode;
  logic upd_bot;
  logic tog_a;
  logic [15:0] top_val;
  logic top_hit;
  logic bottom_hit;
  logic load_cmp;
  logic acc;
  logic setup;
  logic wr;
  logic cnt_wr;
  logic fwr;
  logic [1:0] match;
  logic [1:0] force_hit;
  logic [1:0] oc_nxt;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // top follows the waveform mode only; capture value is read, never disturbed
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmpa,
                                         input logic [15:0] cap);
    case (m)
      `MODE_PC8, `MODE_FAST8: top_of = `TOP_8;
      `MODE_PC9, `MODE_FAST9: top_of = `TOP_9;
      `MODE_PC10, `MODE_FAST10: top_of = `TOP_10;
      `MODE_CLR_A, `MODE_PFC_A, `MODE_PC_A, `MODE_FAST_A: top_of = cmpa;
      `MODE_PFC_CAP, `MODE_PC_CAP, `MODE_CLR_CAP, `MODE_FAST_CAP: top_of = cap;
      default: top_of = `TOP_MAX;
    endcase
  endfunction

  // next output bit of one channel from its action selection
  function automatic logic oc_step(input logic oc, input logic [1:0] act, input logic hit,
                                   input logic at_top, input logic pwm_m, input logic dual_m,
                                   input logic down_m, input logic tog_ok);
    logic r;
    r = oc;
    if (!pwm_m) begin
      if (hit) begin
        case (act)
          `ACT_TOGGLE: r = ~oc;
          `ACT_CLEAR: r = 1'b0;
          `ACT_SET: r = 1'b1;
          default: r = oc;
        endcase
      end
    end else if (hit) begin
      // match wins over top, so compare equal to top gives a steady level
      case (act)
        `ACT_TOGGLE: r = tog_ok ? ~oc : oc;
        `ACT_PWM_NONINV: r = ~(dual_m & down_m);
        `ACT_PWM_INV: r = dual_m & down_m;
        default: r = oc;
      endcase
    end else if (at_top & ~dual_m) begin
      case (act)
        `ACT_PWM_NONINV: r = 1'b0;
        `ACT_PWM_INV: r = 1'b1;
        default: r = oc;
      endcase
    end
    return r;
  endfunction

  // mode decode; the action bits never enter the counting path
  assign pwm = !(q.ctrl.waveform_mode_sel inside {`MODE_NORMAL, `MODE_CLR_A, `MODE_CLR_CAP, `MODE_RSVD});
  assign dual = q.ctrl.waveform_mode_sel inside {`MODE_PC8, `MODE_PC9, `MODE_PC10, `MODE_PFC_CAP,
                                                 `MODE_PFC_A, `MODE_PC_CAP, `MODE_PC_A};
  assign clr_mode = q.ctrl.waveform_mode_sel inside {`MODE_CLR_A, `MODE_CLR_CAP, `MODE_FAST8, `MODE_FAST9,
                                                     `MODE_FAST10, `MODE_FAST_CAP, `MODE_FAST_A};
  assign upd_bot = q.ctrl.waveform_mode_sel inside {`MODE_PFC_CAP, `MODE_PFC_A};
  assign tog_a = q.ctrl.waveform_mode_sel inside {`MODE_FAST_A, `MODE_PFC_A, `MODE_PC_A};
  assign top_val = top_of(q.ctrl.waveform_mode_sel, q.compare_value[0], CAPTURE_VALUE);

  // timer tick from prescaler or external edge; select zero gives no tick at all
  always_comb begin
    case (q.ctrl.clock_source_sel)
      `CS_DIV1: tick = 1'b1;
      `CS_DIV8: tick = (q.presc & `PRE_DIV8) == `PRE_DIV8;
      `CS_DIV64: tick = (q.presc & `PRE_DIV64) == `PRE_DIV64;
      `CS_DIV256: tick = (q.presc & `PRE_DIV256) == `PRE_DIV256;
      `CS_DIV1024: tick = (q.presc & `PRE_DIV1024) == `PRE_DIV1024;
      `CS_EXT_FALL: tick = q.ext_prev & ~EXT_CLK_IN;
      `CS_EXT_RISE: tick = ~q.ext_prev & EXT_CLK_IN;
      default: tick = 1'b0;
    endcase
  end

  // apb phase decode; every write commits at the access edge
  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign acc = APB_REQ.psel & APB_REQ.penable;
  assign wr = acc & APB_REQ.pwrite;
  assign cnt_wr = wr & (APB_REQ.paddr == `OFS_CNT_LO);
  assign fwr = wr & (APB_REQ.paddr == `OFS_FORCE);

  // a count write blocks top and bottom detection on the next tick as well
  assign top_hit = tick & ~q.block & (q.timer_count == top_val);
  assign bottom_hit = tick & ~q.block & q.down & (q.timer_count == `BOTTOM);
  assign load_cmp = pwm & (upd_bot ? bottom_hit : top_hit);

  // per channel comparator and waveform step
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign match[i] = tick & ~q.block & (q.timer_count == q.compare_value[i]);
    assign force_hit[i] = fwr & APB_REQ.pwdata[i] & ~pwm;
    assign oc_nxt[i] = oc_step(q.compare_output_bit[i], q.ctrl.output_action_sel[i],
                               pwm ? match[i] : (match[i] | force_hit[i]), top_hit & clr_mode,
                               pwm, dual, q.down, (i == 0) & tog_a);
    // pin takes the output bit while either action bit is set; direction stays with software
    assign OC_PIN_OUT[i] = (q.ctrl.output_action_sel[i] != `ACT_NONE) ?
                           q.compare_output_bit[i] : q.ctrl.port_val[i];
    assign OC_PIN_OE[i] = q.ctrl.pin_direction_bit[i];
  end

  // flag events: matches, overflow; a forced match sets nothing
  assign flag_set[0] = match[0];
  assign flag_set[1] = match[1];
  assign flag_set[`IDX_OVF] = ~cnt_wr & (dual ? bottom_hit :
                              (pwm ? top_hit : tick & (q.timer_count == `TOP_MAX)));
  assign flag_clr = IRQ_ACK | ({3{wr & (APB_REQ.paddr == `OFS_FLAGS)}} & APB_REQ.pwdata[2:0]);
  assign IRQ_REQ = q.flags & q.irq_en;

  // apb answer: no wait states, read data prepared in the setup cycle
  assign APB_RSP.pready = acc;
  assign APB_RSP.pslverr = acc & q.slverr;
  assign APB_RSP.prdata = q.rdata;

  // whole next state
  always_comb begin
    d = q;
    d.presc = q.presc + 10'h001;
    d.ext_prev = EXT_CLK_IN;
    d.compare_output_bit = oc_nxt; // mode change alone leaves it untouched
    // set wins over a clear in the same cycle
    d.flags = (q.flags & ~flag_clr) | flag_set;
    // counting sequence
    if (tick) begin
      d.block = 1'b0;
      if (dual) begin
        if (!q.down) begin
          d.down = top_hit;
          d.timer_count = top_hit ? q.timer_count - 16'h0001 : q.timer_count + 16'h0001;
        end else begin
          d.down = ~bottom_hit;
          d.timer_count = bottom_hit ? q.timer_count + 16'h0001 : q.timer_count - 16'h0001;
        end
      end else begin
        d.down = 1'b0;
        // normal mode only increments and wraps on its own
        d.timer_count = (clr_mode & top_hit) ? `BOTTOM : q.timer_count + 16'h0001;
      end
    end
    if (load_cmp) begin
      d.compare_value = q.cmp_buf;
    end
    // cpu count write overrides any clear or count, even with the timer stopped
    if (cnt_wr) begin
      d.timer_count = {q.hi_latch, APB_REQ.pwdata[7:0]};
      d.block = 1'b1;
    end
    if (wr) begin
      case (APB_REQ.paddr)
        `OFS_CTRL: d.ctrl = ctrl_t'(APB_REQ.pwdata);
        `OFS_CNT_HI, `OFS_CMPA_HI, `OFS_CMPB_HI: d.hi_latch = APB_REQ.pwdata[7:0];
        `OFS_CMPA_LO: begin
          d.cmp_buf[0] = {q.hi_latch, APB_REQ.pwdata[7:0]};
          if (!pwm) begin
            d.compare_value[0] = {q.hi_latch, APB_REQ.pwdata[7:0]};
          end
        end
        `OFS_CMPB_LO: begin
          d.cmp_buf[1] = {q.hi_latch, APB_REQ.pwdata[7:0]};
          if (!pwm) begin
            d.compare_value[1] = {q.hi_latch, APB_REQ.pwdata[7:0]};
          end
        end
        `OFS_IRQEN: d.irq_en = APB_REQ.pwdata[2:0];
        default: d.irq_en = q.irq_en;
      endcase
    end
    // count low read hands the high byte to the shared latch at the access edge
    if (acc & ~APB_REQ.pwrite & (APB_REQ.paddr == `OFS_CNT_LO)) begin
      d.hi_latch = q.rd_hi;
    end
    // read data for the coming access; compare reads bypass the latch
    if (setup) begin
      d.slverr = 1'b0;
      case (APB_REQ.paddr)
        `OFS_CTRL: d.rdata = 32'(q.ctrl);
        `OFS_CNT_LO: begin
          d.rdata = 32'(q.timer_count[7:0]);
          d.rd_hi = q.timer_count[15:8];
        end
        `OFS_CNT_HI: d.rdata = 32'(q.hi_latch);
        `OFS_CMPA_LO: d.rdata = 32'(pwm ? q.cmp_buf[0][7:0] : q.compare_value[0][7:0]);
        `OFS_CMPA_HI: d.rdata = 32'(pwm ? q.cmp_buf[0][15:8] : q.compare_value[0][15:8]);
        `OFS_CMPB_LO: d.rdata = 32'(pwm ? q.cmp_buf[1][7:0] : q.compare_value[1][7:0]);
        `OFS_CMPB_HI: d.rdata = 32'(pwm ? q.cmp_buf[1][15:8] : q.compare_value[1][15:8]);
        `OFS_FLAGS: d.rdata = 32'(q.flags);
        `OFS_IRQEN: d.rdata = 32'(q.irq_en);
        `OFS_FORCE: d.rdata = '0;
        default: begin
          d.rdata = '0;
          d.slverr = 1'b1;
        end
      endcase
    end
  end

  // single state register; every field resets to zero, output bits included
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_match_flag;
    match[0] |=> q.flags[0];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not set flag a");

  property p_ack_clear;
    IRQ_ACK[1] && !match[1] |=> !q.flags[1] && !IRQ_REQ[1];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("serviced flag b did not clear");

  property p_block;
    cnt_wr |=> q.block && !match[0] && !match[1];
  endproperty
  a_block: assert property (p_block) else $error("match after count write not blocked");

  property p_cnt_prio;
    logic [15:0] v;
    (cnt_wr, v = {q.hi_latch, APB_REQ.pwdata[7:0]}) |=> q.timer_count == v;
  endproperty
  a_cnt_prio: assert property (p_cnt_prio) else $error("count write lost to counting");

  property p_stop;
    q.ctrl.clock_source_sel == `CS_STOP && !cnt_wr |=> $stable(q.timer_count);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");

  property p_wrap;
    tick && !q.block && !cnt_wr && q.ctrl.waveform_mode_sel == `MODE_NORMAL &&
      q.timer_count == `TOP_MAX |=> q.timer_count == `BOTTOM && q.flags[`IDX_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("normal wrap or overflow flag wrong");

  property p_force_noflag;
    force_hit[0] && !match[0] && !q.flags[0] |=> !q.flags[0] && ($stable(q.timer_count) || $past(tick));
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set flag or moved count");

  property p_force_toggle;
    force_hit[0] && !match[0] && q.ctrl.output_action_sel[0] == `ACT_TOGGLE |=>
      q.compare_output_bit[0] != $past(q.compare_output_bit[0]);
  endproperty
  a_force_toggle: assert property (p_force_toggle) else $error("forced toggle missing");

  property p_act_none;
    q.ctrl.output_action_sel[1] == `ACT_NONE && !(wr && APB_REQ.paddr == `OFS_CTRL) |=>
      $stable(q.compare_output_bit[1]);
  endproperty
  a_act_none: assert property (p_act_none) else $error("output moved with action zero");

  property p_dbuf;
    pwm && !load_cmp && !(wr && APB_REQ.paddr == `OFS_CTRL) |=> $stable(q.compare_value[0]);
  endproperty
  a_dbuf: assert property (p_dbuf) else $error("active compare changed outside top/bottom");

  c_flag: cover property (match[1] ##1 IRQ_REQ[1]);
  c_force: cover property (force_hit[1] ##1 $changed(q.compare_output_bit[1]));
  c_ovf: cover property (flag_set[`IDX_OVF] ##1 IRQ_ACK[`IDX_OVF]);
  c_load: cover property (load_cmp && q.cmp_buf[0] != q.compare_value[0]);
endmodule

// ==== tb/cpu_bus_model.sv ====
// cpu side model: apb master transfers and interrupt service into the timer
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic clk,
  output timer16_oc_pkg::apb_req_t apb_req,
  input wire timer16_oc_pkg::apb_rsp_t apb_rsp,
  output logic [2:0] irq_ack
);
  import timer16_oc_pkg::*;

  // idle bus and no acknowledge from time zero
  initial begin
    apb_req = '0;
    irq_ack = 3'h0;
  end

  // one transfer: setup cycle, then access held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic hung);
    int n;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 16);
    // a slave that never answers is reported, not waited on forever
    hung = (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  // interrupt service: one-cycle acknowledge pulse for the serviced sources
  task automatic service(input logic [2:0] which);
    @(posedge clk);
    irq_ack <= which;
    @(posedge clk);
    irq_ack <= 3'h0;
  endtask
endmodule

// ==== tb/timer16_output_compare_units_tb.sv ====
// self-checking bench for the timer compare block through its register bus
`timescale 1ns/1ps
`include "timer16_oc_map.svh"
module timer16_output_compare_units_tb;
  import timer16_oc_pkg::*;
  logic clk;
  logic reset_n;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic ext_clk_in;
  logic [15:0] capture_value;
  logic [2:0] irq_ack;
  logic [2:0] irq_req;
  logic [1:0] oc_pin_out;
  logic [1:0] oc_pin_oe;
  int n_errors = 0;
  int n_tests = 0;
  logic [31:0] r;
  logic e;
  logic [1:0] acts [5] = '{`ACT_CLEAR, `ACT_NONE, `ACT_TOGGLE, `ACT_TOGGLE, `ACT_SET};
  logic exps [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  timer16_oc #(.NUM_CH(2)) dut (.CLK(clk), .RESET_N(reset_n), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
    .EXT_CLK_IN(ext_clk_in), .CAPTURE_VALUE(capture_value), .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req),
    .OC_PIN_OUT(oc_pin_out), .OC_PIN_OE(oc_pin_oe));

  cpu_bus_model cpu (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp), .irq_ack(irq_ack));

  // 10 MHz system clock
  always #50 clk = ~clk;

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic hung;
    cpu.xfer(wr, a, d, r, e, hung);
    if (hung) begin
      $display("[FAIL] bus answer expected 1 seen 0");
      n_errors++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(name, r, exp);
  endtask

  // high byte first into the shared latch, low byte commits the word
  task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
    wr(hi, {24'h0, v[15:8]});
    wr(lo, {24'h0, v[7:0]});
  endtask

  // pins are looked at mid-cycle so the last write's edge has landed
  task automatic pin_chk(input string name, input logic [1:0] exp);
    @(negedge clk);
    chk(name, 32'(oc_pin_out), 32'(exp));
  endtask

  task automatic wait_irq(input int idx);
    int i;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (irq_req[idx] === 1'b1) break;
    end
    chk("irq request", 32'(irq_req[idx]), 32'h1);
    // a request that never comes ends the run through the report
    if (irq_req[idx] !== 1'b1) begin
      test_done();
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [1:0] aa, input logic [2:0] cs, input logic [3:0] m);
    return {17'h0, 2'b10, 2'b11, cs, `ACT_NONE, aa, m};
  endfunction

  // watchdog: a hang ends the run through the same report
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    ext_clk_in = 1'b0;
    capture_value = 16'h0000;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    pin_chk("pin after reset", 2'b00);
    chk("oe after reset", 32'(oc_pin_oe), 32'h0);
    rd("flags after reset", `OFS_FLAGS, 32'h0);
    acc(1'b0, 8'h28, 32'h0);
    chk("unmapped error", 32'(e), 32'h1);
    // compare words through the latch; reads bypass it
    wr16(`OFS_CMPA_HI, `OFS_CMPA_LO, 16'h0105);
    wr(`OFS_CMPA_HI, 32'hAB);
    wr(`OFS_CMPB_LO, 32'hCD);
    rd("cmpb hi", `OFS_CMPB_HI, 32'hAB);
    rd("cmpb lo", `OFS_CMPB_LO, 32'hCD);
    wr(`OFS_CNT_HI, 32'h77);
    rd("cmpa hi", `OFS_CMPA_HI, 32'h01);
    rd("cmpa lo", `OFS_CMPA_LO, 32'h05);
    // stopped counter holds its written value
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0100);
    repeat (5) @(posedge clk);
    rd("count lo stopped", `OFS_CNT_LO, 32'h00);
    rd("count hi stopped", `OFS_CNT_HI, 32'h01);
    // run up to the A match with the set action; B keeps its port value
    // preset the output bit by a forced clear while both pins are still inputs
    wr(`OFS_CTRL, {17'h0, 2'b10, 2'b00, `CS_STOP, `ACT_NONE, `ACT_CLEAR, `MODE_NORMAL});
    wr(`OFS_FORCE, 32'h1);
    pin_chk("pin preset", 2'b10);
    chk("oe before direction", 32'(oc_pin_oe), 32'h0);
    wr(`OFS_IRQEN, 32'h1);
    wr(`OFS_CTRL, ctrl(`ACT_SET, `CS_DIV1, `MODE_NORMAL));
    wait_irq(0);
    pin_chk("pins after match", 2'b11);
    chk("oe as output", 32'(oc_pin_oe), 32'h3);
    rd("flags after match", `OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'h1);
    rd("flags after clear", `OFS_FLAGS, 32'h0);
    // new action waits for a match; the strobe applies it at once without a flag
    wr(`OFS_CTRL, ctrl(`ACT_CLEAR, `CS_STOP, `MODE_NORMAL));
    pin_chk("pin kept until match", 2'b11);
    for (int k = 0; k < 5; k++) begin
      wr(`OFS_CTRL, ctrl(acts[k], `CS_STOP, `MODE_NORMAL));
      wr(`OFS_FORCE, 32'h1);
      pin_chk("forced pin", {1'b1, exps[k]});
    end
    rd("flags after force", `OFS_FLAGS, 32'h0);
    // mode change keeps the output bit; strobe ignored in pwm modes
    wr(`OFS_CTRL, ctrl(`ACT_PWM_NONINV, `CS_STOP, `MODE_FAST8));
    wr(`OFS_FORCE, 32'h1);
    pin_chk("pin after mode change", 2'b11);
    // a count write suppresses the match of the next tick only
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_NORMAL));
    wr16(`OFS_CMPB_HI, `OFS_CMPB_LO, 16'h0200);
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0200);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_DIV1, `MODE_NORMAL));
    repeat (20) @(posedge clk);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_NORMAL));
    rd("blocked match", `OFS_FLAGS, 32'h0);
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h01FF);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_DIV1, `MODE_NORMAL));
    repeat (20) @(posedge clk);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_NORMAL));
    rd("match after one tick", `OFS_FLAGS, 32'h2);
    cpu.service(3'b010);
    rd("flag b after service", `OFS_FLAGS, 32'h0);
    // wrap from the top of the count sets overflow; service clears it
    wr(`OFS_IRQEN, 32'h4);
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'hFFFE);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_DIV1, `MODE_NORMAL));
    wait_irq(2);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_NORMAL));
    acc(1'b0, `OFS_CNT_LO, 32'h0);
    rd("count hi after wrap", `OFS_CNT_HI, 32'h00);
    cpu.service(3'b100);
    rd("flags after service", `OFS_FLAGS, 32'h0);
    // channel a value as top in clear-on-match mode
    wr16(`OFS_CMPA_HI, `OFS_CMPA_LO, 16'h0003);
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0000);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_DIV1, `MODE_CLR_A));
    repeat (50) @(posedge clk);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_CLR_A));
    acc(1'b0, `OFS_CNT_LO, 32'h0);
    chk("count within top", 32'(r <= 32'h3), 32'h1);
    rd("count hi within top", `OFS_CNT_HI, 32'h00);
    // pwm compare writes go to the buffer; the old value keeps matching until top
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_FAST8));
    wr16(`OFS_CMPA_HI, `OFS_CMPA_LO, 16'h0020);
    rd("cmpa buffer read", `OFS_CMPA_LO, 32'h20);
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0000);
    wr(`OFS_FLAGS, 32'h7);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_DIV1, `MODE_FAST8));
    repeat (10) @(posedge clk);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_FAST8));
    rd("old compare still active", `OFS_FLAGS, 32'h1);
    // passing top loads the buffer, so only the new value matches afterwards
    wr16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h00FE);
    wr(`OFS_FLAGS, 32'h7);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_DIV1, `MODE_FAST8));
    repeat (40) @(posedge clk);
    wr(`OFS_CTRL, ctrl(`ACT_NONE, `CS_STOP, `MODE_FAST8));
    rd("new compare after top", `OFS_FLAGS, 32'h5);
    test_done();
  end
endmodule
